// ==== bus_power_status_indicator.sv ====
// Low-power status output with strapped polarity and mode straps
// Notes on behaviour
// - With an EEPROM fitted, configuration comes over the two-wire clock and data pins at power-up.
// - Without an EEPROM, the clock and data pins act as straps for wake-up and power mode.
// - Straps are sampled at power-up; clock high is self-powered, data low means wake-up is supported.
// - The status output is asserted whenever full declared current may not yet be drawn.
// - A configuration of at most one unit load asserts the output only while suspended.
// - A configuration above one unit load asserts it while suspended or not yet configured.
// - The output is deasserted as soon as drawing the full declared current is permitted.
// - The status pin level is sampled at power-up and at every bus reset to set suspend polarity.
// - A high strap gives a high asserted level in suspend, a low strap a low asserted level.
`timescale 1ns/1ns
`include "bus_power_consts.svh"
module bus_power_status_indicator
	import bus_power_pkg::*;
#(
	parameter int RELEASE_CYC = `STRAP_RELEASE_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic eeprom_present,
	input wire logic sclk_in,
	input wire logic sdata_in,
	input wire logic bus_reset,
	input wire logic suspended,
	input wire logic configured,
	input wire logic [7:0] max_power,
	input wire logic status_pin_in,
	output logic power_budget_status_out,
	output logic power_budget_status_oe,
	output logic self_powered_q,
	output logic remote_wakeup_q,
	output logic straps_valid_q,
	output logic asserted_q
);
	logic [2:0] pin_raw;
	logic [2:0] pin_sync;
	logic sclk_s;
	logic sdata_s;
	logic pin_s;
	strap_state_e state_q;
	logic [7:0] cnt_q;
	logic release_done;
	logic sample_now;
	logic strap_take;
	logic polarity_q;
	logic boot_q;
	logic high_power;
	logic want_low;
	logic drive_level;

	// The eight-bit release counter must reach RELEASE_CYC plus two without wrapping
	if (RELEASE_CYC < 1 || RELEASE_CYC > 253) begin : g_bad_release
		$error("RELEASE_CYC out of range");
	end

	// All three pins are asynchronous to clk
	assign pin_raw = {status_pin_in, sdata_in, sclk_in};

	for (genvar i = 0; i < 3; i++) begin : g_pin_sync
		sync2 u_sync (
			.clk(clk),
			.rstn(rstn),
			.d(pin_raw[i]),
			.q(pin_sync[i])
		);
	end

	assign sclk_s = pin_sync[0];
	assign sdata_s = pin_sync[1];
	assign pin_s = pin_sync[2];

	always_comb begin
		release_done = (cnt_q >= 8'(RELEASE_CYC + 2));
		sample_now = (state_q == ST_SAMPLE);
		strap_take = boot_q && sample_now;
	end

	// sample sequencing
	// A bus reset during release is ignored; the sample already under way serves it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= ST_RELEASE;
		end else begin
			case (state_q)
				ST_RELEASE: begin
					if (release_done) begin
						state_q <= ST_SAMPLE;
					end
				end
				ST_SAMPLE: begin
					state_q <= ST_RUN;
				end
				ST_RUN: begin
					if (bus_reset) begin
						state_q <= ST_RELEASE;
					end
				end
				default: begin
					state_q <= ST_RELEASE;
				end
			endcase
		end
	end

	// release counter
	// Release waits long enough for the pull resistor and the synchroniser to settle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 8'h00;
		end else if (state_q != ST_RELEASE) begin
			cnt_q <= 8'h00;
		end else if (!release_done) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	// polarity latch
	// Holds through suspend and resume; only a sample instant may change it
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			polarity_q <= `POLARITY_RESET;
		end else if (sample_now) begin
			polarity_q <= pin_s;
		end
	end

	// power-up strap window
	// Straps only once per power-up; a bus reset does not resample them
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			boot_q <= 1'b1;
		end else if (strap_take) begin
			boot_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			straps_valid_q <= 1'b0;
		end else if (strap_take) begin
			straps_valid_q <= 1'b1;
		end
	end

	// power mode strap
	// With an EEPROM fitted the pins carry the serial bus, so their levels mean nothing here
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			self_powered_q <= 1'b0;
		end else if (strap_take && !eeprom_present) begin
			self_powered_q <= sclk_s;
		end
	end

	// wake-up strap, low level means supported
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			remote_wakeup_q <= 1'b0;
		end else if (strap_take && !eeprom_present) begin
			remote_wakeup_q <= !sdata_s;
		end
	end

	always_comb begin
		high_power = (max_power > `ONE_UNIT_LOAD);
		if (high_power) begin
			want_low = suspended || !configured;
		end else begin
			want_low = suspended;
		end
	end

	// asserted level follows the latched polarity
	always_comb begin
		if (want_low) begin
			drive_level = polarity_q;
		end else begin
			drive_level = !polarity_q;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			asserted_q <= 1'b1;
		end else begin
			asserted_q <= want_low;
		end
	end

	// pin released outside run
	// Drops one cycle after a bus reset is taken; the release count covers that cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			power_budget_status_oe <= 1'b0;
		end else begin
			power_budget_status_oe <= (state_q == ST_RUN);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			power_budget_status_out <= 1'b0;
		end else begin
			power_budget_status_out <= drive_level;
		end
	end
endmodule

// ==== bus_power_consts.svh ====
// Constants for the bus power status indicator
`ifndef BUS_POWER_CONSTS_SVH
`define BUS_POWER_CONSTS_SVH
// One unit load threshold for the descriptor maximum power field
`define ONE_UNIT_LOAD 8'h32
// Release time of the status pin before the polarity sample, in ns
`define STRAP_RELEASE_NS 500
`define CLK_PERIOD_NS 50
`define STRAP_RELEASE_CYC ((`STRAP_RELEASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Reset value of the latched polarity: active high
`define POLARITY_RESET 1'b1
`endif

// ==== bus_power_pkg.sv ====
// Types for the bus power status indicator
package bus_power_pkg;
	typedef enum logic [1:0] {
		ST_RELEASE,
		ST_SAMPLE,
		ST_RUN
	} strap_state_e;
endpackage

// ==== sync2.sv ====
// Two flip-flop synchroniser for one pin level
`timescale 1ns/1ns
module sync2 (
	input wire logic clk,
	input wire logic rstn,
	input wire logic d,
	output logic q
);
	logic meta_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// ==== bus_power_chk.sv ====
// Checker for the bus power status indicator
`timescale 1ns/1ns
module bus_power_chk #(parameter int RELEASE_CYC = 10) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic eeprom_present,
	input wire logic bus_reset,
	input wire logic suspended,
	input wire logic configured,
	input wire logic [7:0] max_power,
	input wire logic power_budget_status_out,
	input wire logic power_budget_status_oe,
	input wire logic self_powered_q,
	input wire logic remote_wakeup_q,
	input wire logic straps_valid_q,
	input wire logic asserted_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_low_mode: assert property (max_power <= 8'h32 |=> asserted_q == $past(suspended)) else $error("low");
	a_high_mode: assert property (max_power > 8'h32 |=> asserted_q == $past(suspended | !configured)) else $error("hi");
	a_out_hold: assert property ((power_budget_status_oe && $stable(asserted_q))[*3] |-> $stable(power_budget_status_out))
		else $error("out");
	a_bus_release: assert property (bus_reset && power_budget_status_oe |-> ##2 !power_budget_status_oe) else $error("rel");
	a_release_len: assert property ($rose(power_budget_status_oe) |-> !$past(power_budget_status_oe, RELEASE_CYC + 4))
		else $error("len");
	a_straps_hold: assert property (straps_valid_q |=> $stable(self_powered_q) && $stable(remote_wakeup_q))
		else $error("strap");
	a_eeprom_ignore: assert property ($rose(straps_valid_q) && eeprom_present |-> !self_powered_q) else $error("ee");
	a_wake_ignore: assert property ($rose(straps_valid_q) && eeprom_present |-> !remote_wakeup_q) else $error("wk");
	cover property ($rose(power_budget_status_oe));
	cover property (bus_reset && power_budget_status_oe);
	cover property (asserted_q && max_power > 8'h32);
endmodule
bind bus_power_status_indicator bus_power_chk #(.RELEASE_CYC(RELEASE_CYC)) chk_i (
	.clk(clk),
	.rstn(rstn),
	.eeprom_present(eeprom_present),
	.bus_reset(bus_reset),
	.suspended(suspended),
	.configured(configured),
	.max_power(max_power),
	.power_budget_status_out(power_budget_status_out),
	.power_budget_status_oe(power_budget_status_oe),
	.self_powered_q(self_powered_q),
	.remote_wakeup_q(remote_wakeup_q),
	.straps_valid_q(straps_valid_q),
	.asserted_q(asserted_q)
);

// ==== usb_host_model.sv ====
// Host side: suspend, configuration and bus reset levels
`timescale 1ns/1ns
module usb_host_model (
	output logic suspended,
	output logic configured,
	output logic bus_reset
);
	task put(logic s, logic c, logic r);
		suspended = s;
		configured = c;
		bus_reset = r;
	endtask
	initial put(1'b0, 1'b0, 1'b0);
endmodule

// ==== bus_power_status_indicator_test.sv ====
// Self-checking bench for the bus power status indicator
`timescale 1ns/1ns
module bus_power_status_indicator_test;
	logic clk = 0, rstn = 0, eeprom_present = 0, sclk_in = 1, sdata_in = 0, pull = 1, status_pin_in;
	logic suspended, configured, bus_reset, power_budget_status_out, power_budget_status_oe;
	logic self_powered_q, remote_wakeup_q, straps_valid_q, asserted_q;
	logic [7:0] max_power = 8'h32;
	int err_total = 0, cmp_count = 0;
	// Released pin settles to the strap resistor
	assign status_pin_in = power_budget_status_oe ? power_budget_status_out : pull;
	bus_power_status_indicator #(.RELEASE_CYC(1)) dut (
		.clk(clk),
		.rstn(rstn),
		.eeprom_present(eeprom_present),
		.sclk_in(sclk_in),
		.sdata_in(sdata_in),
		.bus_reset(bus_reset),
		.suspended(suspended),
		.configured(configured),
		.max_power(max_power),
		.status_pin_in(status_pin_in),
		.power_budget_status_out(power_budget_status_out),
		.power_budget_status_oe(power_budget_status_oe),
		.self_powered_q(self_powered_q),
		.remote_wakeup_q(remote_wakeup_q),
		.straps_valid_q(straps_valid_q),
		.asserted_q(asserted_q)
	);
	usb_host_model host (
		.suspended(suspended),
		.configured(configured),
		.bus_reset(bus_reset)
	);
	initial forever #25 clk = ~clk;
	task step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(string n, logic e, logic g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %b got %b", n, e, g);
		end
	endtask
	task print_verdict;
		if (err_total == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Bounded wait for the pin enable to reach a level
	task wait_oe(logic lvl);
		int i;
		for (i = 0; i < 40 && power_budget_status_oe !== lvl; i++)
			step(1);
		chk("oe", lvl, power_budget_status_oe);
		if (i == 40)
			print_verdict;
	endtask
	task do_reset;
		rstn = 1'b0;
		step(8);
		chk("oe_in_reset", 1'b0, power_budget_status_oe);
		chk("valid_in_reset", 1'b0, straps_valid_q);
		rstn = 1'b1;
		wait_oe(1'b1);
		chk("valid", 1'b1, straps_valid_q);
	endtask
	// Power-up without EEPROM: clock strap high, data strap low
	task power_up_straps;
		do_reset;
		chk("self", 1'b1, self_powered_q);
		chk("wake", 1'b1, remote_wakeup_q);
	endtask
	// Bus reset resamples polarity from the pull-down; the power-up straps stay
	task bus_reset_resample;
		pull = 1'b0;
		sclk_in = 1'b0;
		host.put(1'b0, 1'b1, 1'b1);
		step(1);
		host.put(1'b0, 1'b1, 1'b0);
		wait_oe(1'b0);
		wait_oe(1'b1);
		chk("self", 1'b1, self_powered_q);
	endtask
	// With an EEPROM the straps would read self-powered with wake-up, yet must be ignored
	task eeprom_fitted;
		eeprom_present = 1'b1;
		sclk_in = 1'b1;
		sdata_in = 1'b0;
		do_reset;
		chk("self", 1'b0, self_powered_q);
		chk("wake", 1'b0, remote_wakeup_q);
	endtask
	// Every suspend, configured and class mix; level follows the latched polarity
	task modes(logic pol);
		for (int k = 0; k < 8; k++) begin
			max_power = k[2] ? 8'h33 : 8'h32;
			host.put(k[0], k[1], 1'b0);
			step(3);
			chk("asserted", k[0] | (k[2] & !k[1]), asserted_q);
			chk("level", (k[0] | (k[2] & !k[1])) ~^ pol, power_budget_status_out);
		end
	endtask
	initial begin
		power_up_straps;
		modes(1'b1);
		bus_reset_resample;
		modes(1'b0);
		eeprom_fitted;
		print_verdict;
	end
endmodule
